// file: rtl/sts_pkg.sv
// constants and types for the self-test sequencer
package sts_pkg;
   localparam int STS_NUM_LOGIC = 6;
   localparam int STS_NUM_MEM = 8;
   localparam int STS_SHIFT_CYCLES = 50;
   localparam int STS_CAPTURE_CYCLES = 25;
   localparam int STS_PATTERN_CYCLES = STS_SHIFT_CYCLES + STS_CAPTURE_CYCLES;
   localparam int STS_PCS_W = 16;
   localparam int STS_SHS_W = 4;
   localparam int STS_WDG_W = 8;
   // access watchdog length in clock cycles (hard coded)
   localparam logic [7:0] STS_WDG_RELOAD = 8'h3c;
   // key codes, values arbitrary
   localparam logic [31:0] STS_KEY1 = 32'h1234abcd;
   localparam logic [31:0] STS_KEY2 = 32'hedcb4321;
   localparam logic STS_CLK_PLL = 1'b0;
   localparam logic STS_CLK_RC = 1'b1;
   typedef enum logic [1:0] {
      STS_LK_LOCKED,
      STS_LK_HALF,
      STS_LK_OPEN
   } sts_lock_t;
   typedef enum logic [2:0] {
      STS_IDLE,
      STS_MEM,
      STS_GAP,
      STS_LOGIC,
      STS_DONE,
      STS_FAULT
   } sts_state_t;
endpackage : sts_pkg

// file: rtl/sts_key_guard.sv
// key unlock and access watchdog
`timescale 1ns/1ps
module sts_key_guard import sts_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // key writes and run status
   input wire logic key_wr,
   input wire logic [31:0] key_data,
   input wire logic run_started,
   // status
   output logic unlocked,
   output logic wdg_timeout
);
   sts_lock_t lock_r;
   sts_lock_t lock_nxt;
   logic [STS_WDG_W-1:0] wdg_r;
   logic [STS_WDG_W-1:0] wdg_nxt;
   logic to_r;
   wire is_k1 = key_wr && key_data == STS_KEY1;
   wire is_k2 = key_wr && key_data == STS_KEY2;
   wire expire = lock_r == STS_LK_OPEN && !run_started && wdg_r == '0;

   always_comb begin
      lock_nxt = lock_r;
      wdg_nxt = wdg_r;
      case (lock_r)
         STS_LK_LOCKED: if (is_k1) lock_nxt = STS_LK_HALF;
         STS_LK_HALF: begin
            if (is_k2) begin
               lock_nxt = STS_LK_OPEN;
               wdg_nxt = STS_WDG_RELOAD;
            end else if (key_wr) begin
               lock_nxt = STS_LK_LOCKED;
            end
         end
         STS_LK_OPEN: begin
            if (expire) begin
               lock_nxt = STS_LK_LOCKED;
            end else if (is_k2) begin
               wdg_nxt = STS_WDG_RELOAD;
            end else if (!run_started) begin
               wdg_nxt = wdg_r - 1'b1;
            end
         end
         default: lock_nxt = STS_LK_LOCKED;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_r <= STS_LK_LOCKED;
         wdg_r <= '0;
         to_r <= 1'b0;
      end else begin
         lock_r <= lock_nxt;
         wdg_r <= wdg_nxt;
         if (expire) to_r <= 1'b1;
         else if (lock_r == STS_LK_HALF && is_k2) to_r <= 1'b0;
      end
   end

   assign unlocked = lock_r == STS_LK_OPEN;
   assign wdg_timeout = to_r;
endmodule : sts_key_guard

// file: rtl/sts_logic_pacer.sv
// paces one logic partition test: patterns of shift and capture cycles
`timescale 1ns/1ps
module sts_logic_pacer import sts_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // control
   input wire logic start,
   input wire logic [STS_PCS_W-1:0] pattern_stop_count,
   input wire logic [STS_SHS_W-1:0] shift_speed_field,
   // pacing outputs
   output logic busy,
   output logic cycle_strobe,
   output logic capture_phase,
   output logic done
);
   logic busy_r;
   logic [STS_SHS_W-1:0] stretch_r;
   logic [6:0] cyc_r;
   logic [STS_PCS_W-1:0] pat_r;
   logic done_r;
   wire step = busy_r && stretch_r == shift_speed_field;
   wire last_cyc = cyc_r == 7'(STS_PATTERN_CYCLES - 1);
   wire last_pat = pat_r == pattern_stop_count - 1'b1;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_r <= 1'b0;
         stretch_r <= '0;
         cyc_r <= '0;
         pat_r <= '0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start && !busy_r) begin
            busy_r <= pattern_stop_count != '0;
            done_r <= pattern_stop_count == '0;
            stretch_r <= '0;
            cyc_r <= '0;
            pat_r <= '0;
         end else if (busy_r) begin
            // each cycle lasts shift speed plus one clocks
            stretch_r <= step ? '0 : stretch_r + 1'b1;
            if (step) begin
               cyc_r <= last_cyc ? '0 : cyc_r + 1'b1;
               if (last_cyc) begin
                  pat_r <= pat_r + 1'b1;
                  if (last_pat) begin
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                  end
               end
            end
         end
      end
   end

   assign busy = busy_r;
   assign done = done_r;
   assign cycle_strobe = step;
   assign capture_phase = busy_r && cyc_r >= 7'(STS_SHIFT_CYCLES);
endmodule : sts_logic_pacer

// file: rtl/sts_sequencer.sv
// self-test sequencer: memory tests, then logic tests, then reset, fault or fail report
`timescale 1ns/1ps
module sts_sequencer import sts_pkg::*; #(
   parameter int NUM_MEM = STS_NUM_MEM,
   parameter int NUM_LOGIC = STS_NUM_LOGIC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // reset causes that trigger an off-line run
   input wire logic power_up_event,
   input wire logic reset_pin_event,
   input wire logic output_supervision_reset,
   // configuration record loader / software writes
   input wire logic config_record_valid,
   input wire logic key_wr,
   input wire logic [31:0] key_data,
   input wire logic cfg_wr,
   input wire logic online_trigger,
   // memory test configuration
   input wire logic [NUM_MEM-1:0] mem_enable,
   input wire logic [NUM_MEM-1:0] concurrent_mode_select,
   input wire logic [NUM_MEM-1:0] mem_group_sequential,
   input wire logic [NUM_MEM-1:0] mem_same_group_prev,
   // logic test configuration
   input wire logic [NUM_LOGIC-1:0] logic_enable,
   input wire logic [NUM_LOGIC*STS_PCS_W-1:0] logic_pattern_count_reg,
   input wire logic [NUM_LOGIC*STS_SHS_W-1:0] logic_partition_control,
   // fault mapping
   input wire logic [NUM_LOGIC-1:0] logic_fault_unrecoverable,
   input wire logic [NUM_MEM-1:0] mem_fault_unrecoverable,
   // memory self-test controllers
   output logic [NUM_MEM-1:0] memory_self_test_start,
   input wire logic [NUM_MEM-1:0] memory_self_test_done,
   input wire logic [NUM_MEM-1:0] memory_self_test_fail,
   // logic self-test controllers
   output logic [NUM_LOGIC-1:0] logic_self_test_run,
   output logic logic_cycle_strobe,
   output logic logic_capture_phase,
   input wire logic [NUM_LOGIC-1:0] logic_self_test_fail,
   // clock, reset and status
   output logic clk_sel_rc,
   output logic chip_reset_req,
   output logic hold_in_reset,
   output logic fault_external,
   output logic fail_report,
   output logic busy,
   output logic access_unlocked,
   output logic wdg_timeout_err
);
   sts_state_t state_r;
   sts_state_t state_nxt;
   logic offline_r;
   logic [NUM_MEM-1:0] mem_pend_r;
   logic [NUM_MEM-1:0] mem_run_r;
   logic [NUM_LOGIC-1:0] lg_pend_r;
   logic [2:0] lg_idx_r;
   logic lg_start_r;
   logic fail_unrec_r;
   logic fail_rec_r;
   logic clk_rc_r;
   logic chip_rst_r;
   logic hold_r;
   logic fault_ext_r;
   logic fail_rep_r;
   logic busy_r;
   logic unl_r;
   logic to_r;
   logic [NUM_LOGIC-1:0] lg_run_r;
   logic strobe_r;
   logic capt_r;

   logic unlocked;
   logic wdg_to;
   logic pc_busy;
   logic pc_strobe;
   logic pc_capt;
   logic pc_done;
   logic [NUM_MEM-1:0] mem_launch;
   logic [NUM_MEM-1:0] mem_done_now;
   logic [NUM_LOGIC-1:0] lg_fail_sel;
   logic [NUM_LOGIC-1:0] lg_run_nxt;

   wire run_started = state_r != STS_IDLE;
   wire reset_cause = power_up_event | reset_pin_event |
      output_supervision_reset;
   // offline start after records loaded while held in reset
   wire go_offline = reset_cause && config_record_valid &&
      unlocked;
   wire go_online = online_trigger && unlocked && !wdg_to;
   wire mem_all_done = mem_pend_r == '0 && mem_run_r == '0;
   wire mem_fail_now = |(memory_self_test_done & memory_self_test_fail &
      mem_run_r);
   wire mem_unrec_now = |(memory_self_test_done & memory_self_test_fail &
      mem_run_r & mem_fault_unrecoverable);
   wire [STS_PCS_W-1:0] cur_pcs =
      logic_pattern_count_reg[lg_idx_r*STS_PCS_W +: STS_PCS_W];
   wire [STS_SHS_W-1:0] cur_shs =
      logic_partition_control[lg_idx_r*STS_SHS_W +: STS_SHS_W];
   wire lg_fail_now = pc_done && |lg_fail_sel;
   wire lg_unrec_now = pc_done && |(lg_fail_sel & logic_fault_unrecoverable);
   wire lg_last = lg_pend_r == '0 && !pc_busy && !lg_start_r;
   wire any_fail = fail_unrec_r | fail_rec_r;
   // next values of the registered outputs
   // off-line gaps run from the RC oscillator, on-line gaps stay on the PLL
   wire clk_rc_nxt = (offline_r && state_r == STS_GAP) ? STS_CLK_RC :
      STS_CLK_PLL;
   // a failed off-line run must not release the chip from reset
   wire chip_rst_nxt = state_r == STS_DONE &&
      !(offline_r && any_fail);
   wire hold_nxt = state_r == STS_FAULT && offline_r;
   wire fault_ext_nxt = state_r == STS_FAULT;
   wire busy_nxt = state_r != STS_IDLE && state_r != STS_DONE &&
      state_r != STS_FAULT;
   // key access is only reported while no run has been started
   wire unl_nxt = unlocked && !run_started;
   wire [NUM_MEM-1:0] mem_start_nxt = state_r == STS_MEM ? mem_launch :
      '0;

   assign mem_done_now = memory_self_test_done & mem_run_r;

   // memory launch decision, one slot per partition
   genvar gi;
   generate
      for (gi = 0; gi < NUM_MEM; gi++) begin : g_mem
         if (gi == 0) begin : g_first
            assign mem_launch[gi] = mem_pend_r[gi];
         end else begin : g_rest
            // a partition may start beside a concurrent predecessor
            // unless both share a sequential group
            wire blocked_seq = mem_same_group_prev[gi] &&
               mem_group_sequential[gi] &&
               (mem_pend_r[gi-1] || mem_run_r[gi-1]);
            // one behind a non-concurrent predecessor waits for all earlier to end
            wire blocked_ord = !concurrent_mode_select[gi-1] &&
               (|mem_pend_r[gi-1:0] || |mem_run_r[gi-1:0]);
            wire blocked_any = (|mem_pend_r[gi-1:0]) &&
               !concurrent_mode_select[gi-1];
            assign mem_launch[gi] = mem_pend_r[gi] && !blocked_seq &&
               !blocked_ord && !blocked_any;
         end
      end
      for (gi = 0; gi < NUM_LOGIC; gi++) begin : g_lfail
         assign lg_fail_sel[gi] = logic_self_test_fail[gi] &&
            lg_idx_r == 3'(gi);
      end
      for (gi = 0; gi < NUM_LOGIC; gi++) begin : g_lrun
         assign lg_run_nxt[gi] = pc_busy && lg_idx_r == 3'(gi);
      end
   endgenerate

   sts_key_guard u_key (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .key_wr(key_wr),
      .key_data(key_data),
      .run_started(run_started),
      .unlocked(unlocked),
      .wdg_timeout(wdg_to)
   );

   sts_logic_pacer u_pacer (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .start(lg_start_r),
      .pattern_stop_count(cur_pcs),
      .shift_speed_field(cur_shs),
      .busy(pc_busy),
      .cycle_strobe(pc_strobe),
      .capture_phase(pc_capt),
      .done(pc_done)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         STS_IDLE: if (go_offline || go_online) state_nxt = STS_MEM;
         STS_MEM: begin
            if (mem_unrec_now) state_nxt = STS_FAULT;
            else if (mem_all_done) state_nxt = STS_GAP;
         end
         // one cycle with no partition running between tests
         STS_GAP: state_nxt = lg_pend_r == '0 ? STS_DONE : STS_LOGIC;
         STS_LOGIC: begin
            if (lg_unrec_now) state_nxt = STS_FAULT;
            else if (pc_done && lg_last) state_nxt = STS_DONE;
            else if (pc_done) state_nxt = STS_GAP;
         end
         STS_DONE: state_nxt = STS_DONE;
         STS_FAULT: state_nxt = STS_FAULT;
         default: state_nxt = STS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= STS_IDLE;
         offline_r <= 1'b0;
         mem_pend_r <= '0;
         mem_run_r <= '0;
         lg_pend_r <= '0;
         lg_idx_r <= '0;
         lg_start_r <= 1'b0;
         fail_unrec_r <= 1'b0;
         fail_rec_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         lg_start_r <= 1'b0;
         if (state_r == STS_IDLE && (go_offline || go_online)) begin
            offline_r <= go_offline;
            mem_pend_r <= mem_enable;
            lg_pend_r <= logic_enable;
         end
         if (state_r == STS_MEM) begin
            mem_pend_r <= mem_pend_r & ~mem_launch;
            // controller decides its own length; wait for its done
            mem_run_r <= (mem_run_r & ~mem_done_now) | mem_launch;
         end
         if (state_r == STS_GAP && lg_pend_r != '0 && !pc_busy) begin
            lg_start_r <= 1'b1;
            for (int i = NUM_LOGIC - 1; i >= 0; i--) begin
               if (lg_pend_r[i]) lg_idx_r <= 3'(i);
            end
         end
         if (lg_start_r) lg_pend_r[lg_idx_r] <= 1'b0;
         // recoverable faults are only noted; the run carries on to its end
         if (mem_fail_now && !mem_unrec_now) fail_rec_r <= 1'b1;
         if (lg_fail_now && !lg_unrec_now) fail_rec_r <= 1'b1;
         if (mem_unrec_now || lg_unrec_now) fail_unrec_r <= 1'b1;
      end
   end

   // registered outputs
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_rc_r <= STS_CLK_PLL;
         chip_rst_r <= 1'b0;
         hold_r <= 1'b0;
         fault_ext_r <= 1'b0;
         fail_rep_r <= 1'b0;
         busy_r <= 1'b0;
         unl_r <= 1'b0;
         to_r <= 1'b0;
         lg_run_r <= '0;
         strobe_r <= 1'b0;
         capt_r <= 1'b0;
      end else begin
         clk_rc_r <= clk_rc_nxt;
         chip_rst_r <= chip_rst_nxt;
         hold_r <= hold_nxt;
         fault_ext_r <= fault_ext_nxt;
         fail_rep_r <= fail_rec_r;
         busy_r <= busy_nxt;
         unl_r <= unl_nxt;
         to_r <= wdg_to;
         lg_run_r <= lg_run_nxt;
         strobe_r <= pc_strobe;
         capt_r <= pc_capt;
      end
   end

   // memory start strobes are registered in a process of their own
   logic [NUM_MEM-1:0] mem_start_r;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) mem_start_r <= '0;
      else mem_start_r <= mem_start_nxt;
   end

   assign memory_self_test_start = mem_start_r;
   assign logic_self_test_run = lg_run_r;
   assign logic_cycle_strobe = strobe_r;
   assign logic_capture_phase = capt_r;
   assign clk_sel_rc = clk_rc_r;
   assign chip_reset_req = chip_rst_r;
   assign hold_in_reset = hold_r;
   assign fault_external = fault_ext_r;
   assign fail_report = fail_rep_r;
   assign busy = busy_r;
   assign access_unlocked = unl_r;
   assign wdg_timeout_err = to_r;
   // cfg_wr is accepted only while the key guard reports unlocked, even during a run
   wire cfg_ignored = cfg_wr && !unlocked;
endmodule : sts_sequencer

// file: test/sts_seq_properties.sv
// port-level checks for the self-test sequencer
`timescale 1ns/1ps
module sts_seq_properties import sts_pkg::*; #(
   parameter int NUM_MEM = STS_NUM_MEM,
   parameter int NUM_LOGIC = STS_NUM_LOGIC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // key writes
   input wire logic key_wr,
   input wire logic [31:0] key_data,
   // test controllers
   input wire logic [NUM_MEM-1:0] memory_self_test_start,
   input wire logic [NUM_LOGIC-1:0] logic_self_test_run,
   input wire logic logic_cycle_strobe,
   // status
   input wire logic clk_sel_rc,
   input wire logic chip_reset_req,
   input wire logic hold_in_reset,
   input wire logic fault_external,
   input wire logic busy,
   input wire logic access_unlocked,
   input wire logic wdg_timeout_err
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic [7:0] since_key_r;
   wire key1_w = key_wr && key_data == STS_KEY1;
   wire key2_w = key_wr && key_data == STS_KEY2;
   wire in_logic_w = |logic_self_test_run;
   // cycles since the last key write, saturating
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         since_key_r <= 8'h00;
      end else if (key_wr) begin
         since_key_r <= 8'h00;
      end else if (since_key_r != 8'hff) begin
         since_key_r <= since_key_r + 8'h01;
      end
   end
   a_logic_one_hot: assert property ($onehot0(logic_self_test_run))
      else $error("two logic tests run together");
   a_strobe_in_test: assert property (logic_cycle_strobe |-> in_logic_w)
      else $error("cycle strobe outside a logic test");
   a_start_one_pulse: assert property
      (!(|(memory_self_test_start & $past(memory_self_test_start))))
      else $error("memory start longer than one cycle");
   a_mem_before_logic: assert property
      (in_logic_w |-> memory_self_test_start == '0)
      else $error("memory start during a logic test");
   a_pll_in_test: assert property
      (in_logic_w && $past(in_logic_w) |-> !clk_sel_rc)
      else $error("rc clock chosen during a logic test");
   a_unlock_delay: assert property
      (key1_w ##1 key2_w |-> ##[1:3] access_unlocked)
      else $error("key pair did not unlock");
   a_wdg_length: assert property
      ($rose(wdg_timeout_err) |-> since_key_r >= 8'h3a && since_key_r <= 8'h40)
      else $error("watchdog expired at wrong time");
   a_wdg_relocks: assert property
      (wdg_timeout_err |-> !access_unlocked && !busy)
      else $error("access open or run after time-out");
   a_fault_holds: assert property
      (hold_in_reset |-> fault_external && !chip_reset_req)
      else $error("held fault not signalled or reset issued");
   a_reset_after_logic: assert property
      (chip_reset_req |-> !in_logic_w)
      else $error("chip reset while a logic test runs");
   c_logic_run: cover property ($rose(in_logic_w));
   c_timeout: cover property ($rose(wdg_timeout_err));
   c_chip_reset: cover property ($rose(chip_reset_req));
endmodule : sts_seq_properties

bind sts_sequencer sts_seq_properties #(
   .NUM_MEM(NUM_MEM), .NUM_LOGIC(NUM_LOGIC)
) u_props (
   .sys_clk(sys_clk), .reset_n(reset_n), .key_wr(key_wr),
   .key_data(key_data), .memory_self_test_start(memory_self_test_start),
   .logic_self_test_run(logic_self_test_run),
   .logic_cycle_strobe(logic_cycle_strobe), .clk_sel_rc(clk_sel_rc),
   .chip_reset_req(chip_reset_req), .hold_in_reset(hold_in_reset),
   .fault_external(fault_external), .busy(busy),
   .access_unlocked(access_unlocked), .wdg_timeout_err(wdg_timeout_err)
);

// file: test/sts_ctrl_model.sv
// behavioural memory and logic self-test controllers
`timescale 1ns/1ps
module sts_ctrl_model #(
   parameter int NUM_MEM = 8,
   parameter int NUM_LOGIC = 6,
   parameter int MEM_CYCLES = 20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // memory controllers
   input wire logic [NUM_MEM-1:0] mem_start,
   output logic [NUM_MEM-1:0] mem_done,
   output logic [NUM_MEM-1:0] mem_fail,
   output logic [NUM_MEM-1:0] mem_active,
   // logic controllers
   input wire logic [NUM_LOGIC-1:0] logic_run,
   output logic [NUM_LOGIC-1:0] logic_fail,
   // injected results
   input wire logic [NUM_MEM-1:0] mem_fail_cfg,
   input wire logic [NUM_LOGIC-1:0] logic_fail_cfg
);
   int cnt [NUM_MEM];
   // results are only valid with done or run; otherwise show the opposite
   assign mem_fail = (mem_done & mem_fail_cfg) | (~mem_done & ~mem_fail_cfg);
   assign logic_fail = (logic_run & logic_fail_cfg) |
                       (~logic_run & ~logic_fail_cfg);
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_done <= '0;
         mem_active <= '0;
      end else begin
         for (int i = 0; i < NUM_MEM; i++) begin
            mem_done[i] <= 1'b0;
            if (mem_start[i]) begin
               mem_active[i] <= 1'b1;
               cnt[i] <= MEM_CYCLES;
            end else if (mem_active[i]) begin
               cnt[i] <= cnt[i] - 1;
               if (cnt[i] == 1) begin
                  mem_active[i] <= 1'b0;
                  mem_done[i] <= 1'b1;
               end
            end
         end
      end
   end
endmodule : sts_ctrl_model

// file: test/sts_sequencer_tb.sv
// self-checking testbench for the self-test sequencer
`timescale 1ns/1ps
module sts_sequencer_tb import sts_pkg::*;;
   logic sys_clk, reset_n, key_wr, cfg_wr, online_trigger, config_record_valid;
   logic power_up_event, reset_pin_event, output_supervision_reset;
   logic [31:0] key_data;
   logic [7:0] mem_enable, concurrent_mode_select, mem_group_sequential;
   logic [7:0] mem_same_group_prev, mem_fault_unrecoverable, mem_active;
   logic [7:0] memory_self_test_start, memory_self_test_done;
   logic [7:0] memory_self_test_fail;
   logic [5:0] logic_enable, logic_fault_unrecoverable, logic_fail_cfg;
   logic [5:0] logic_self_test_run, logic_self_test_fail;
   logic [95:0] logic_pattern_count_reg;
   logic [23:0] logic_partition_control;
   logic logic_cycle_strobe, logic_capture_phase, clk_sel_rc, chip_reset_req;
   logic hold_in_reset, fault_external, fail_report, busy, access_unlocked;
   logic wdg_timeout_err;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   // run0 cycles, strobes, captures, max mem overlap, rc seen, clash, runs
   int mon [7];
   sts_sequencer DUT (
      .sys_clk, .reset_n, .power_up_event, .reset_pin_event,
      .output_supervision_reset, .config_record_valid, .key_wr, .key_data,
      .cfg_wr, .online_trigger, .mem_enable, .concurrent_mode_select,
      .mem_group_sequential, .mem_same_group_prev, .logic_enable,
      .logic_pattern_count_reg, .logic_partition_control,
      .logic_fault_unrecoverable, .mem_fault_unrecoverable,
      .memory_self_test_start, .memory_self_test_done,
      .memory_self_test_fail, .logic_self_test_run, .logic_cycle_strobe,
      .logic_capture_phase, .logic_self_test_fail, .clk_sel_rc,
      .chip_reset_req, .hold_in_reset, .fault_external, .fail_report, .busy,
      .access_unlocked, .wdg_timeout_err
   );
   sts_ctrl_model #(.MEM_CYCLES(20)) u_model (
      .sys_clk, .reset_n, .mem_start(memory_self_test_start),
      .mem_done(memory_self_test_done), .mem_fail(memory_self_test_fail),
      .mem_active, .logic_run(logic_self_test_run),
      .logic_fail(logic_self_test_fail), .mem_fail_cfg(8'h00), .logic_fail_cfg
   );
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
      if (busy === 1'b1 && clk_sel_rc === 1'b1) mon[4] = 1;
      mon[6] |= logic_self_test_run;
      if (logic_self_test_run[0] === 1'b1) begin
         mon[0]++;
         mon[1] += logic_cycle_strobe;
         mon[2] += logic_cycle_strobe && logic_capture_phase;
      end
      if ($countones(mem_active) > mon[3]) mon[3] = $countones(mem_active);
      if (mem_active[0] && mem_active[1]) mon[5] = 1;
   end
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #5;
   endtask : tick
   task automatic do_reset(logic [2:0] causes);
      reset_n = 1'b0;
      key_wr = 1'b0;
      online_trigger = 1'b0;
      {power_up_event, reset_pin_event, output_supervision_reset} = causes;
      config_record_valid = |causes;
      tick(16);
      mon = '{default: 0};
      reset_n = 1'b1;
   endtask : do_reset
   task automatic unlock();
      key_wr = 1'b1;
      key_data = STS_KEY1;
      tick(1);
      key_data = STS_KEY2;
      tick(1);
      key_wr = 1'b0;
      tick(1);
      chk("access_unlocked", 1, access_unlocked);
   endtask : unlock
   task automatic trigger();
      online_trigger = 1'b1;
      tick(1);
      online_trigger = 1'b0;
   endtask : trigger
   task automatic wait_end();
      int n;
      n = 0;
      while ((chip_reset_req | hold_in_reset | fail_report) !== 1'b1
             && n < 5000) begin
         tick(1);
         n++;
      end
      chk("sequence end", 1, n < 5000);
   endtask : wait_end
   task automatic t_online();
      logic_fail_cfg = 6'h00;
      do_reset(3'b000);
      unlock();
      trigger();
      wait_end();
      chk("chip_reset_req", 1, chip_reset_req);
      chk("rc clock seen", 0, mon[4]);
      chk("partitions run", 6'h3f, mon[6]);
      chk("part0 strobes", 2 * STS_PATTERN_CYCLES, mon[1]);
      chk("part0 captures", 2 * STS_CAPTURE_CYCLES, mon[2]);
      chk("part0 length", 1, mon[0] >= 300 && mon[0] <= 304);
      chk("mem overlap", 3, mon[3]);
      chk("seq group clash", 0, mon[5]);
   endtask : t_online
   task automatic t_offline(int k);
      logic_fail_cfg = (k == 0) ? 6'h00 : 6'h04;
      logic_fault_unrecoverable = (k == 1) ? 6'h04 : 6'h00;
      do_reset(3'b100 >> k);
      unlock();
      wait_end();
      chk("chip_reset_req", k == 0, chip_reset_req);
      chk("hold_in_reset", k == 1, hold_in_reset);
      chk("fault_external", k == 1, fault_external);
      chk("fail_report", k == 2, fail_report);
      if (k == 0) chk("rc clock seen", 1, mon[4]);
   endtask : t_offline
   task automatic t_watchdog();
      do_reset(3'b000);
      trigger();
      tick(5);
      chk("busy while locked", 0, busy);
      unlock();
      key_data = STS_KEY2;
      repeat (4) begin
         key_wr = 1'b1;
         tick(1);
         key_wr = 1'b0;
         tick(29);
      end
      chk("timeout after reloads", 0, wdg_timeout_err);
      tick(70);
      chk("wdg_timeout_err", 1, wdg_timeout_err);
      chk("access_unlocked", 0, access_unlocked);
      trigger();
      tick(5);
      chk("busy after timeout", 0, busy);
   endtask : t_watchdog
   task automatic finish_test();
      if (fail_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      cfg_wr = 1'b0;
      key_data = '0;
      mem_enable = 8'h0f;
      concurrent_mode_select = 8'h07;
      mem_group_sequential = 8'h03;
      mem_same_group_prev = 8'h02;
      mem_fault_unrecoverable = 8'h00;
      logic_enable = 6'h3f;
      logic_fault_unrecoverable = 6'h00;
      logic_fail_cfg = 6'h00;
      logic_pattern_count_reg = {{5{16'h0001}}, 16'h0002};
      logic_partition_control = {{5{4'h0}}, 4'h1};
      t_online();
      for (int k = 0; k < 3; k++) begin
         t_offline(k);
      end
      t_watchdog();
      finish_test();
   end
endmodule : sts_sequencer_tb
